/* src/iwc_top.sv */
// iwc_top: front wiper intermittent relay and washer motor control
// assumes raw switch pins from the harness and a sampled delay setting
`timescale 1ns/10ps

// Behaviour
// - wipe and wash only start in power ON
// - crank: washer off now, wiper parks
// - other power states stop both outputs immediately
// - only intermittent mode is driven here
// - park switch active means blade parked
// - switch to off finishes current sweep
// - flick seen as low speed via park
// - external low speed detected, never driven
// - relay on: request, ignition, no crank
// - relay released when blade reaches park
// - positions 0..4 give 3..15 s pause
// - open circuit setting gives 6 s pause
// - crank blocks next sweep, resume after
// - shorter delay: wipe at once, then shorter
// - longer delay stretches the current pause
// - relay low active, wash/park inputs low active
module iwc_top import iwc_pkg::*; #(
  parameter int unsigned SEC_CYC = TICK_CYC,  // cycles per second tick
  parameter int unsigned DB_CYC  = DEB_CYC    // debounce cycles
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // power state pins
  input  wire logic             ign_in,
  input  wire logic             crank_in,
  // driver switches and park contact
  input  wire logic             int_req_n,
  input  wire logic             wash_sw_n,
  input  wire logic             park_sw_n,
  // delay setting sample
  input  wire logic [ADC_W-1:0] dly_adc_code,
  input  wire logic             dly_adc_valid,
  // actuators
  output logic                  int_relay_n,
  output logic                  wash_motor,
  // status
  output logic                  ext_wipe_active
);

  localparam int unsigned TW = $clog2(SEC_CYC + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(SEC_CYC - 1);

  // ------------------------------------------------------------------
  // input conditioning
  // ------------------------------------------------------------------
  iwc_sw_t  sw;       // debounced, active high
  iwc_dly_t dly_sel;  // quantised delay setting
  logic [4:0] sw_vec;

  // low active pins are inverted before filtering
  wire [4:0] raw_vec = {ign_in, crank_in, ~int_req_n, ~wash_sw_n, ~park_sw_n};

  // park assumed during reset, so no phantom sweep is seen
  iwc_debounce #(
    .N       (5),
    .DEB     (DB_CYC),
    .RST_VAL (5'h01)
  ) u_deb (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .raw_in    (raw_vec),
    .clean_out (sw_vec)
  );
  assign sw = sw_vec;

  iwc_quant u_quant (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .adc_code  (dly_adc_code),
    .adc_valid (dly_adc_valid),
    .dly_out   (dly_sel)
  );

  // ------------------------------------------------------------------
  // power state decode
  // ------------------------------------------------------------------
  wire pwr_on    = sw.ign & ~sw.crank;  // normal run
  wire pwr_crank = sw.ign & sw.crank;   // engine cranking
  wire pwr_off   = ~sw.ign;             // key in, accessory or key out

  // ------------------------------------------------------------------
  // delay selection
  // ------------------------------------------------------------------
  // pause length in seconds, 3 s per step above zero
  wire [3:0] dly_step = 4'(({1'b0, dly_sel.pos} + 4'h1) * DLY_STEP_S);
  // open circuit falls back to the default pause
  wire [3:0] dly_s    = dly_sel.open ? DLY_DEFAULT_S : dly_step;
  logic [3:0] dly_prev_r;  // setting seen last cycle
  // only a drop triggers a wipe; a rise just stretches the wait
  wire dly_dec = dly_s < dly_prev_r;

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  iwc_state_t state_r;
  iwc_state_t state_nxt;
  logic [TW-1:0] tick_r;    // cycles within the current second
  logic [3:0]    sec_r;     // whole seconds paused
  logic          park_d_r;  // park level last cycle
  logic [3:0]    quiet_r;   // seconds parked while externally run
  logic          ext_run_r; // wiper moved by the column switch

  wire tick       = tick_r == TICK_LAST;
  wire park_edge  = sw.park ^ park_d_r;
  wire pause_done = sec_r >= dly_s;
  wire start_ok   = pwr_on & sw.int_req & ~ext_run_r;
  wire pause_go   = start_ok & (pause_done | dly_dec);
  wire pause_in   = state_r == ST_RETURN && sw.park && state_nxt == ST_PAUSE;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // no start outside power ON request, ignition, no crank
        if (start_ok) begin
          state_nxt = ST_LEAVE;
        end
      end
      ST_LEAVE: begin
        // off states cut at once crank lets the sweep run
        if (pwr_off) begin
          state_nxt = ST_IDLE;
        end else if (!sw.park) begin
          state_nxt = ST_RETURN;
        end
      end
      ST_RETURN: begin
        // sweep completes even if the mode goes off
        if (pwr_off) begin
          state_nxt = ST_IDLE;
        end else if (sw.park) begin
          // park contact ends the sweep
          state_nxt = sw.int_req ? ST_PAUSE : ST_IDLE;
        end
      end
      ST_PAUSE: begin
        // crank holds the next sweep until released
        if (pwr_off || !sw.int_req) begin
          state_nxt = ST_IDLE;
        end else if (pause_go) begin
          state_nxt = ST_LEAVE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // relay follows the next state so a stop takes effect in one edge
  wire relay_nxt = state_nxt == ST_LEAVE || state_nxt == ST_RETURN;
  // washer runs only in power ON, drops at once on crank or off
  wire wash_nxt  = pwr_on & sw.wash;

  // state, relay and washer registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r     <= ST_IDLE;
      int_relay_n <= 1'b1;
      wash_motor  <= 1'b0;
      dly_prev_r  <= DLY_DEFAULT_S;
    end else begin
      state_r     <= state_nxt;
      int_relay_n <= ~relay_nxt;  // low drives the relay
      wash_motor  <= wash_nxt;
      dly_prev_r  <= dly_s;
    end
  end

  // ------------------------------------------------------------------
  // seconds timebase, restarted when the blade parks into a pause
  // ------------------------------------------------------------------
  // restarting keeps the first second whole, at the cost of a free tick
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tick_r <= '0;
      sec_r  <= '0;
    end else if (pause_in) begin
      tick_r <= '0;
      sec_r  <= '0;
    end else if (tick) begin
      tick_r <= '0;
      if (sec_r != 4'hf) begin
        sec_r <= sec_r + 4'h1;
      end
    end else begin
      tick_r <= tick_r + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // external wipe detection (flick, low and high)
  // ------------------------------------------------------------------
  // park toggling while we do not drive means the column switch does
  wire ext_seen = park_edge && (state_r == ST_IDLE || state_r == ST_PAUSE);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      park_d_r  <= 1'b1;
      ext_run_r <= 1'b0;
      quiet_r   <= '0;
    end else begin
      park_d_r <= sw.park;
      if (ext_seen) begin
        ext_run_r <= 1'b1;
        quiet_r   <= '0;
      end else if (ext_run_r && tick) begin
        if (!sw.park) begin
          quiet_r <= '0;
        end else if (quiet_r == 4'(EXT_QUIET_S - 1)) begin
          ext_run_r <= 1'b0;
          quiet_r   <= '0;
        end else begin
          quiet_r <= quiet_r + 4'h1;
        end
      end
    end
  end

  assign ext_wipe_active = ext_run_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_off_stop;
    pwr_off |=> int_relay_n && !wash_motor;
  endproperty
  a_off_stop: assert property (p_off_stop) else $error("outputs alive when off");

  property p_no_start;
    state_r == ST_IDLE && !pwr_on |=> state_r == ST_IDLE && int_relay_n;
  endproperty
  a_no_start: assert property (p_no_start) else $error("start outside ON");

  property p_crank_wash;
    pwr_crank |=> !wash_motor;
  endproperty
  a_crank_wash: assert property (p_crank_wash) else $error("wash during crank");

  property p_crank_park;
    state_r == ST_RETURN && pwr_crank && !sw.park |=> !int_relay_n;
  endproperty
  a_crank_park: assert property (p_crank_park) else $error("crank cut sweep");

  // dropping the request mid-sweep must not cut the relay before park
  property p_off_finish;
    state_r == ST_RETURN && !sw.int_req && !sw.park && sw.ign |=> !int_relay_n;
  endproperty
  a_off_finish: assert property (p_off_finish) else $error("sweep cut on mode off");

  property p_start;
    state_r == ST_IDLE && start_ok |=> !int_relay_n && state_r == ST_LEAVE;
  endproperty
  a_start: assert property (p_start) else $error("relay not energised");

  property p_release;
    state_r == ST_RETURN && sw.park && sw.ign |=> int_relay_n;
  endproperty
  a_release: assert property (p_release) else $error("relay held at park");

  // the blade leaving park moves the sweep on to its return leg
  property p_park_leave;
    state_r == ST_LEAVE && !sw.park && sw.ign |=> state_r == ST_RETURN;
  endproperty
  a_park_leave: assert property (p_park_leave) else $error("park release missed");

  property p_pause_len;
    state_r == ST_LEAVE && $past(state_r) == ST_PAUSE
      |-> $past(dly_dec) || $past(sec_r) >= $past(dly_s);
  endproperty
  a_pause_len: assert property (p_pause_len) else $error("pause too short");

  property p_decrease;
    state_r == ST_PAUSE && start_ok && dly_dec |=> !int_relay_n;
  endproperty
  a_decrease: assert property (p_decrease) else $error("no wipe on shorter delay");

  property p_crank_hold;
    state_r == ST_PAUSE && pwr_crank |=> state_r != ST_LEAVE;
  endproperty
  a_crank_hold: assert property (p_crank_hold) else $error("sweep during crank");

  // once crank drops and the pause is over, the next sweep starts
  property p_crank_resume;
    state_r == ST_PAUSE && pwr_on && sw.int_req && !ext_run_r && sec_r >= dly_s
      |=> !int_relay_n;
  endproperty
  a_crank_resume: assert property (p_crank_resume) else $error("no sweep after crank");

  // an unfinished pause with no drop in setting keeps the relay off
  property p_pause_hold;
    state_r == ST_PAUSE && sec_r < dly_s && !dly_dec |=> int_relay_n;
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("pause cut short");

  property p_pause_zero;
    pause_in |=> state_r == ST_PAUSE && sec_r == 4'h0 && tick_r == '0;
  endproperty
  a_pause_zero: assert property (p_pause_zero) else $error("pause not from park");

  property p_open_default;
    dly_sel.open |-> dly_s == DLY_DEFAULT_S;
  endproperty
  a_open_default: assert property (p_open_default) else $error("bad default");

  property p_ext_idle;
    state_r == ST_IDLE && ext_run_r |=> state_r == ST_IDLE;
  endproperty
  a_ext_idle: assert property (p_ext_idle) else $error("drove during ext wipe");

  // a park edge while idle marks an externally driven wipe
  property p_ext_set;
    state_r == ST_IDLE && park_edge |=> ext_wipe_active;
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("external wipe missed");

  // an external wipe is never dropped while the blade is off park
  property p_ext_hold;
    ext_run_r && !sw.park |=> ext_run_r;
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("external wipe dropped");

  // washer follows its switch while power is ON
  property p_wash_on;
    pwr_on && sw.wash |=> wash_motor;
  endproperty
  a_wash_on: assert property (p_wash_on) else $error("washer not started");

  // ------------------------------------------------------------------
  // scenario covers
  // ------------------------------------------------------------------
  c_full_cycle: cover property (state_r == ST_RETURN ##1 state_r == ST_PAUSE);
  c_dly_drop:   cover property (state_r == ST_PAUSE && dly_dec);
  c_crank_park: cover property (state_r == ST_RETURN && pwr_crank);
  c_ext_run:    cover property ($rose(ext_run_r));
  c_crank_hold: cover property (state_r == ST_PAUSE && pwr_crank && pause_done);

endmodule

/* src/iwc_pkg.sv */
// iwc_pkg: shared constants and types for the intermittent wiper control
// assumes a 10 MHz system clock; all times below are in their own unit
package iwc_pkg;

  // ------------------------------------------------------------------
  // clock and timebase
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 10_000_000;   // sys_clk rate
  localparam int unsigned TICK_MS     = 1000;         // pause timebase, 1 s
  localparam int unsigned DEBOUNCE_MS = 20;           // switch settle time
  localparam int unsigned EXT_QUIET_S = 3;            // park idle before ext run ends
  localparam int unsigned TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DEB_CYC     = CLK_HZ / 1000 * DEBOUNCE_MS;

  // ------------------------------------------------------------------
  // delay steps
  // ------------------------------------------------------------------
  localparam logic [3:0] DLY_STEP_S    = 4'h3;  // seconds per position step
  localparam logic [3:0] DLY_DEFAULT_S = 4'h6;  // open circuit pause
  localparam logic [2:0] DLY_POS_MAX   = 3'h4;  // last valid position
  localparam int unsigned ADC_W        = 8;     // delay setting sample width

  // position band upper bounds; above the last lies open circuit
  localparam logic [7:0] ADC_TH0  = 8'h33;
  localparam logic [7:0] ADC_TH1  = 8'h66;
  localparam logic [7:0] ADC_TH2  = 8'h99;
  localparam logic [7:0] ADC_TH3  = 8'hcc;
  localparam logic [7:0] ADC_OPEN = 8'hf0;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  // debounced switches, all active high after conversion
  typedef struct packed {
    logic ign;      // ignition on
    logic crank;    // crank on
    logic int_req;  // intermittent requested
    logic wash;     // wash switch pressed
    logic park;     // blade at park position
  } iwc_sw_t;

  // quantised delay setting
  typedef struct packed {
    logic       open;  // setting input open circuit
    logic [2:0] pos;   // position 0..4
  } iwc_dly_t;

  // intermittent sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,  // relay off, nothing scheduled
    ST_LEAVE  = 2'b01,  // relay on, blade still on park
    ST_RETURN = 2'b10,  // relay on, blade sweeping back
    ST_PAUSE  = 2'b11   // relay off, timing the gap
  } iwc_state_t;

endpackage

/* src/iwc_debounce.sv */
// iwc_debounce: two-flop synchroniser plus stability filter, one per bit
// assumes asynchronous switch levels; output changes only after a stable run
`timescale 1ns/10ps
module iwc_debounce import iwc_pkg::*; #(
  parameter int unsigned   N       = 5,        // number of inputs
  parameter int unsigned   DEB     = DEB_CYC,  // settle time in cycles
  parameter logic [N-1:0]  RST_VAL = '0        // value shown during reset
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         srst,
  // raw and filtered levels
  input  wire logic [N-1:0] raw_in,
  output logic      [N-1:0] clean_out
);

  localparam int unsigned CW = $clog2(DEB + 1);
  localparam logic [CW-1:0] DEB_LAST = CW'(DEB - 1);

  // ------------------------------------------------------------------
  // per bit filter
  // ------------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_bit
    logic          s1_r;   // first sync stage, read only by s2_r
    logic          s2_r;   // second sync stage
    logic [CW-1:0] cnt_r;  // cycles the new level has held
    wire           differs = s2_r != clean_out[i];

    // a short glitch restarts the count, so chatter never gets through
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        s1_r         <= RST_VAL[i];
        s2_r         <= RST_VAL[i];
        cnt_r        <= '0;
        clean_out[i] <= RST_VAL[i];
      end else begin
        s1_r <= raw_in[i];
        s2_r <= s1_r;
        if (!differs) begin
          cnt_r <= '0;
        end else if (cnt_r == DEB_LAST) begin
          cnt_r        <= '0;
          clean_out[i] <= s2_r;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

endmodule

/* src/iwc_quant.sv */
// iwc_quant: turns the delay setting sample into a position or open circuit
// assumes the converter runs on sys_clk and marks fresh samples with valid
`timescale 1ns/10ps
module iwc_quant import iwc_pkg::*; (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // converter sample
  input  wire logic [ADC_W-1:0] adc_code,
  input  wire logic             adc_valid,
  // quantised setting
  output iwc_dly_t              dly_out
);

  // ------------------------------------------------------------------
  // band decode
  // ------------------------------------------------------------------
  wire      is_open = adc_code >= ADC_OPEN;
  wire [2:0] band   = (adc_code < ADC_TH0) ? 3'h0 :
                      (adc_code < ADC_TH1) ? 3'h1 :
                      (adc_code < ADC_TH2) ? 3'h2 :
                      (adc_code < ADC_TH3) ? 3'h3 : DLY_POS_MAX;
  iwc_dly_t dly_nxt;
  assign dly_nxt.open = is_open;
  assign dly_nxt.pos  = is_open ? 3'h1 : band;

  // ------------------------------------------------------------------
  // held result; open circuit shows at reset so the default pause applies
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dly_out <= '{open: 1'b1, pos: 3'h1};
    end else if (adc_valid) begin
      dly_out <= dly_nxt;
    end
  end

endmodule

/* verification/iwc_motor_model.sv */
// iwc_motor_model: wiper motor with its park contact, for the bench
// assumes the relay feed is active low and ext_run stands for stalk power
`timescale 1ns/10ps
module iwc_motor_model #(
  parameter int SWEEP = 40,  // steps in one full sweep
  parameter int PZ    = 12   // steps inside the park zone
) (
  // clock
  input  wire logic sys_clk,
  // motor feeds
  input  wire logic relay_n,  // intermittent relay, low = fed
  input  wire logic ext_run,  // flick or low speed feed
  input  wire logic slow,     // half speed blade
  // park contact
  output logic      park_sw_n
);
  // ----------------------------------------------------------------
  // blade position
  // ----------------------------------------------------------------
  logic [7:0] pos_r  = 8'h00;  // blade position in steps
  logic       half_r = 1'b0;   // divider for slow running

  // blade moves while fed; stops dead mid-glass if the feed drops,
  // so a design that cuts the relay early is seen at once
  always @(posedge sys_clk) begin
    half_r <= ~half_r;
    if ((!relay_n || ext_run) && (!slow || half_r)) begin
      pos_r <= (pos_r == 8'(SWEEP - 1)) ? 8'h00 : pos_r + 8'h01;
    end
  end

  // contact closes to ground across the park zone, open reads high
  assign park_sw_n = (pos_r >= 8'(PZ));
endmodule

/* verification/tb.sv */
// tb: self-checking bench for the intermittent wiper control
// assumes short second and debounce counts, and a motor model on park
`timescale 1ns/10ps
module tb import iwc_pkg::*; ;
  // ----------------------------------------------------------------
  // settings and signals
  // ----------------------------------------------------------------
  localparam int SEC   = 20;                // cycles per second tick
  localparam int DB    = 4;                 // debounce cycles
  localparam int SWEEP = 40;                // motor steps per sweep
  localparam int PZ    = 12;                // park zone steps
  localparam int SW_LO = SWEEP - PZ;        // shortest sweep gap
  localparam int SW_HI = 2 * SWEEP + DB + 8; // longest sweep gap, slow
  localparam int BIG   = 99999;             // gap not checked

  typedef struct {
    logic [2:0] o;   // {relay_n, wash, ext}
    int         lo;  // least cycles since last change
    int         hi;  // most cycles since last change
  } iwc_note_t;

  // band starts of the setting input; each band is 16 codes or wider
  localparam logic [7:0] LO[6] = '{8'h00, 8'h33, 8'h66, 8'h99, 8'hcc, 8'hf0};
  localparam int         S[6]  = '{3, 6, 9, 12, 15, 6};  // pause seconds

  logic             sys_clk       = 1'b0;
  logic             srst          = 1'b1;
  logic             ign_in        = 1'b0;
  logic             crank_in      = 1'b0;
  logic             int_req_n     = 1'b1;
  logic             wash_sw_n     = 1'b1;
  logic             park_sw_n;
  logic [ADC_W-1:0] dly_adc_code  = 8'hff;
  logic             dly_adc_valid = 1'b0;
  logic             ext_run       = 1'b0;
  logic             slow          = 1'b0;
  logic             int_relay_n;
  logic             wash_motor;
  logic             ext_wipe_active;
  logic [2:0]       prev          = 3'b100;  // outputs at last look
  int               n_fail        = 0;
  int               checked       = 0;
  int               cyc           = 0;
  int               last          = 0;       // cycle of last change
  iwc_note_t        notes[$];                // expected output changes

  always #50 sys_clk = ~sys_clk;

  iwc_top #(.SEC_CYC(SEC), .DB_CYC(DB)) uut (
    .sys_clk(sys_clk), .srst(srst), .ign_in(ign_in), .crank_in(crank_in),
    .int_req_n(int_req_n), .wash_sw_n(wash_sw_n), .park_sw_n(park_sw_n),
    .dly_adc_code(dly_adc_code), .dly_adc_valid(dly_adc_valid),
    .int_relay_n(int_relay_n), .wash_motor(wash_motor),
    .ext_wipe_active(ext_wipe_active)
  );

  iwc_motor_model #(.SWEEP(SWEEP), .PZ(PZ)) motor (
    .sys_clk(sys_clk), .relay_n(int_relay_n), .ext_run(ext_run),
    .slow(slow), .park_sw_n(park_sw_n)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic fail(input string msg);
    $display("MISMATCH at %0t: %s", $time, msg);
    n_fail++;
  endtask

  task automatic end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // note an expected output change with its gap window
  task automatic note(input logic [2:0] o, input int lo, input int hi);
    notes.push_back('{o, lo, hi});
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // bounded wait until at most n notes are still open
  task automatic wait_q(input int n);
    int k;
    for (k = 0; k < 3000 && notes.size() > n; k++) @(negedge sys_clk);
    if (notes.size() > n) begin
      fail("no output change in time");
      end_sim();
    end
  endtask

  // one valid sample of the delay setting
  task automatic set_dly(input logic [7:0] c);
    dly_adc_code  = c;
    dly_adc_valid = 1'b1;
    @(negedge sys_clk);
    dly_adc_valid = 1'b0;
  endtask

  // drop the request mid-sweep; the blade must still reach park
  task automatic finish_req;
    wait_q(1);
    int_req_n = 1'b1;
    wait_q(0);
    idle(30);
  endtask

  // ----------------------------------------------------------------
  // watcher: every output change must match the oldest note
  // ----------------------------------------------------------------
  always @(negedge sys_clk) begin : watch
    iwc_note_t n;
    cyc++;
    if (!srst && {int_relay_n, wash_motor, ext_wipe_active} !== prev) begin
      checked++;
      if (notes.size() == 0) fail("output change not expected");
      else begin
        n = notes.pop_front();
        if (n.o !== {int_relay_n, wash_motor, ext_wipe_active} ||
            cyc - last < n.lo || cyc - last > n.hi) begin
          fail($sformatf("out %b want %b gap %0d", {int_relay_n, wash_motor,
               ext_wipe_active}, n.o, cyc - last));
        end
      end
      last = cyc;
    end
    prev = {int_relay_n, wash_motor, ext_wipe_active};
  end

  // ----------------------------------------------------------------
  // stimulus, driven at the falling edge
  // ----------------------------------------------------------------
  initial begin
    idle(4);
    srst = 1'b0;
    checked++;
    if ({int_relay_n, wash_motor, ext_wipe_active} !== 3'b100) fail("reset");
    void'($urandom(76));
    ign_in = 1'b1;
    idle(DB + 10);
    // a pulse shorter than the debounce must leave no trace
    int_req_n = 1'b0;
    idle(2);
    int_req_n = 1'b1;
    idle(20);
    // every setting band, a random code in each, random blade speed
    for (int k = 0; k < 6; k++) begin
      slow = 1'($urandom % 2);
      set_dly(LO[k] + 8'($urandom % 16));
      note(3'b000, 0, BIG);
      note(3'b100, SW_LO, SW_HI);
      note(3'b000, (S[k] - 1) * SEC, (S[k] + 1) * SEC);
      note(3'b100, SW_LO, SW_HI);
      int_req_n = 1'b0;
      finish_req();
    end
    slow = 1'b0;
    // crank held through the pause, sweep resumes after it
    set_dly(8'h10);
    int_req_n = 1'b0;
    note(3'b000, 0, BIG);
    note(3'b100, SW_LO, SW_HI);
    wait_q(0);
    idle(10);
    crank_in = 1'b1;
    idle(90);
    note(3'b000, 100, 100 + DB + 10);
    crank_in = 1'b0;
    note(3'b100, SW_LO, SW_HI);
    finish_req();
    // shorter delay in a long pause: wipe at once, then short pauses
    set_dly(8'hd0);
    int_req_n = 1'b0;
    note(3'b000, 0, BIG);
    note(3'b100, SW_LO, SW_HI);
    wait_q(0);
    idle(20);
    note(3'b000, 18, 30);
    set_dly(8'h10);
    note(3'b100, SW_LO, SW_HI);
    note(3'b000, 2 * SEC, 4 * SEC);
    note(3'b100, SW_LO, SW_HI);
    finish_req();
    // longer delay in a short pause: no extra wipe, then long pauses
    int_req_n = 1'b0;
    note(3'b000, 0, BIG);
    note(3'b100, SW_LO, SW_HI);
    wait_q(0);
    idle(10);
    set_dly(8'hd0);
    note(3'b000, 2 * SEC, 16 * SEC);
    note(3'b100, SW_LO, SW_HI);
    note(3'b000, 14 * SEC, 16 * SEC);
    note(3'b100, SW_LO, SW_HI);
    finish_req();
    // one stalk-driven sweep: seen on park only, relay left alone
    note(3'b101, 0, BIG);
    note(3'b100, SW_LO + 2 * SEC, SW_LO + 4 * SEC + DB + 8);
    ext_run = 1'b1;
    idle(SWEEP + 1);
    ext_run = 1'b0;
    wait_q(0);
    idle(20);
    // crank mid-sweep: washer off now, wiper runs on to park
    note(3'b110, 0, BIG);
    wash_sw_n = 1'b0;
    wait_q(0);
    note(3'b010, DB, DB + 8);
    int_req_n = 1'b0;
    wait_q(0);
    idle(15);
    note(3'b000, 15 + DB, 15 + DB + 8);
    note(3'b100, 5, SWEEP + DB + 8);
    crank_in = 1'b1;
    wait_q(0);
    wash_sw_n = 1'b1;
    int_req_n = 1'b1;
    idle(20);
    crank_in = 1'b0;
    idle(100);
    // ignition off mid-sweep: both outputs drop at once, none restart
    note(3'b110, 0, BIG);
    wash_sw_n = 1'b0;
    wait_q(0);
    note(3'b010, DB, DB + 8);
    int_req_n = 1'b0;
    wait_q(0);
    idle(20);
    note(3'b100, 20 + DB, 20 + DB + 8);
    ign_in = 1'b0;
    wait_q(0);
    idle(100);
    end_sim();
  end
endmodule
